// *** verification/imarx_group_regs_tb.sv ***
`timescale 1ns/10ps
module imarx_group_regs_tb;
  import imarx_pkg::*;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [IMARX_AW-1:0] addr_in = '0;
  logic [IMARX_DW-1:0] wdata_in = '0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [IMARX_GROUPS-1:0] cell_in = '0;
  logic [IMARX_DW-1:0] rdata_out;
  logic [IMARX_GROUPS-1:0] check_id_out, acquire_len_out, group_en_out, usable_to_active_ok_out;
  logic [IMARX_GROUPS-1:0] resync_en_out, drain_out;
  logic [IMARX_GROUPS*2-1:0] symmetry_out;
  logic [IMARX_GROUPS*9-1:0] frame_len_out;
  logic [IMARX_GROUPS*4-1:0] link_count_out;
  int n_mismatch = 0;
  int n_checks = 0;
  logic [7:0] d, c, r;
  logic [15:0] n;
  int g;

  imarx_group_regs imarx_group_regs_inst (.clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .cell_in(cell_in),
    .check_id_out(check_id_out), .acquire_len_out(acquire_len_out), .symmetry_out(symmetry_out),
    .frame_len_out(frame_len_out), .group_en_out(group_en_out),
    .usable_to_active_ok_out(usable_to_active_ok_out), .resync_en_out(resync_en_out),
    .drain_out(drain_out), .link_count_out(link_count_out));

  always #5 clk_in = ~clk_in;

  function automatic logic [10:0] lo_addr(input int gi);
    return IMARX_CNT_LOW_BASE + IMARX_BANK_STEP * 11'(gi / 4) + IMARX_CNT_STEP * 11'(gi % 4);
  endfunction : lo_addr
  function automatic logic [10:0] cfg_addr(input int gi);
    return IMARX_CONFIG_BASE + IMARX_BANK_STEP * 11'(gi / 4) + IMARX_CFG_STEP * 11'(gi % 4);
  endfunction : cfg_addr

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk
  // all bus tasks start and end just after a rising edge
  task automatic wr(input logic [10:0] a, input logic [7:0] v);
    addr_in = a;
    wdata_in = v;
    wr_in = 1'b1;
    @(posedge clk_in);
    #1 wr_in = 1'b0;
    // idle edge so a following call never rewrites the strobe in the same step
    @(posedge clk_in);
    #1;
  endtask : wr
  task automatic rd(input logic [10:0] a, output logic [7:0] v);
    addr_in = a;
    rd_in = 1'b1;
    @(posedge clk_in);
    #1 rd_in = 1'b0;
    v = rdata_out;
    @(posedge clk_in);
    #1;
  endtask : rd
  task automatic cells(input int gi, input int k);
    cell_in = IMARX_GROUPS'(1) << gi;
    repeat (k) @(posedge clk_in);
    #1 cell_in = '0;
  endtask : cells
  task automatic settle();
    repeat (2) @(posedge clk_in);
    #1;
  endtask : settle
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  initial begin
    #900000;
    n_mismatch++;
    test_done();
  end

  initial begin
    void'($urandom(73));
    repeat (3) @(posedge clk_in);
    #1 srst_in = 1'b0;
    chk(16'(frame_len_out[8:0]), 16'(IMARX_M32), "reset frame length");
    chk(16'(link_count_out[3:0]), 16'(IMARX_LINKS_ONE), "reset link count");
    rd(11'h7FF, r);
    chk(16'(r), 16'h0000, "unmapped read");
    for (int i = 0; i < 16; i++) begin
      g = (i < 2) ? i * 15 : int'($urandom % 16);
      d = 8'($urandom) & IMARX_CONFIG_MASK;
      c = 8'($urandom) & IMARX_CONTROL_MASK;
      d[1:0] = 2'(i);
      c[2:0] = 3'(i);
      wr(cfg_addr(g), d);
      wr(cfg_addr(g) + 11'h001, c);
      settle();
      chk(16'(check_id_out[g]), 16'(d[7]), "check id");
      chk(16'(acquire_len_out[g]), 16'(d[6]), "acquire length");
      chk(16'(symmetry_out[g*2+:2]), 16'(d[3:2]), "symmetry");
      chk(16'(frame_len_out[g*9+:9]), 16'(IMARX_M32 << d[1:0]), "frame length");
      chk(16'(group_en_out[g]), 16'(c[7]), "group enable");
      chk(16'(usable_to_active_ok_out[g]), 16'(c[6]), "timeout");
      chk(16'(resync_en_out[g]), 16'(c[5]), "resync");
      chk(16'(drain_out[g]), 16'(c[4]), "drain");
      chk(16'(link_count_out[g*4+:4]), 16'({1'b0, c[2:0]}) + 16'h0001, "link count");
      rd(cfg_addr(g), r);
      chk(16'(r), 16'(d & IMARX_CONFIG_MASK), "config readback");
      rd(cfg_addr(g) + 11'h001, r);
      chk(16'(r), 16'(c & IMARX_CONTROL_MASK), "control readback");
    end
    // reset in mid-run drops every control back to its idle value
    srst_in = 1'b1;
    @(posedge clk_in);
    #1 srst_in = 1'b0;
    settle();
    chk(16'(group_en_out), 16'h0000, "enable after reset");
    for (int i = 0; i < 3; i++) begin
      g = (i == 0) ? 0 : int'($urandom % 16);
      n = 16'(($urandom % 700) + 256);
      cells(g, int'(n));
      wr(lo_addr(g), IMARX_SNAP_CMD);
      cells(g, 5);
      wr(lo_addr(g) + 11'h001, 8'hAA);
      rd(lo_addr(g), r);
      chk(16'(r), 16'(n[7:0]), "snapshot low");
      rd(lo_addr(g) + 11'h001, r);
      chk(16'(r), 16'(n[15:8]), "snapshot high");
      rd(lo_addr(g), r);
      chk(16'(r), 16'h0000, "cleared by high read");
      wr(lo_addr(g), 8'h02);
      rd(lo_addr(g), r);
      chk(16'(r), 16'h0000, "other value keeps snapshot");
      wr(lo_addr(g), IMARX_LIVE_CMD);
      rd(lo_addr(g) + 11'h001, r);
      chk(16'(r), 16'h0000, "live high");
      rd(lo_addr(g), r);
      chk(16'(r), 16'h0005, "live low");
      cells(g, 1);
      wr(lo_addr(g), 8'h7F);
      rd(lo_addr(g), r);
      chk(16'(r), 16'h0006, "odd command ignored");
      wr(lo_addr(g), IMARX_SNAP_CMD);
      wr(lo_addr(g), IMARX_LIVE_CMD);
    end
    cells(15, 65537);
    wr(lo_addr(15), IMARX_SNAP_CMD);
    rd(lo_addr(15), r);
    chk(16'(r), 16'h0001, "wrap low");
    rd(lo_addr(15) + 11'h001, r);
    chk(16'(r), 16'h0000, "wrap high");
    test_done();
  end
endmodule : imarx_group_regs_tb

// *** verilog/imarx_group_regs.sv ***
`timescale 1ns/10ps
// Contract
// - each group keeps a 16-bit count of received cells, upper byte shown at the high counter address.
// - writing 0x01 to the group's low counter address copies all 16 bits to holding registers and clears the count.
// - writing 0x00 to the low counter address makes the counter addresses show the live count again.
// - the high counter register is read-only and a read in snapshot mode clears the reported value.
// - check-group-id set makes framing compare received group id, clear ignores it.
// - acquire-frame-length set adopts received length and version, clear compares them.
// - the symmetry field selects one of four symmetry modes.
// - the frame length field selects 32, 64, 128 or 256 cells per frame.
// - group enable establishes the group and its link round-robin, clear leaves it down.
// - timeout-expired set allows usable to active link transitions, clear blocks them.
// - resync set runs differential delay synchronisation, clear disables it.
// - drain set lets the delay buffer drain excess cells, clear buffers normally.
// - the group size field 0 to 7 means one to eight links.
// - the low count byte is shown at the low counter address with the same live or snapshot selection, but reading it does not clear the reported value.
module imarx_group_regs (
  // clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // register port
  input wire logic [imarx_pkg::IMARX_AW-1:0] addr_in,
  input wire logic [imarx_pkg::IMARX_DW-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [imarx_pkg::IMARX_DW-1:0] rdata_out,
  // cell events, one bit per group
  input wire logic [imarx_pkg::IMARX_GROUPS-1:0] cell_in,
  // framing controls per group
  output logic [imarx_pkg::IMARX_GROUPS-1:0] check_id_out,
  output logic [imarx_pkg::IMARX_GROUPS-1:0] acquire_len_out,
  output logic [imarx_pkg::IMARX_GROUPS*2-1:0] symmetry_out,
  output logic [imarx_pkg::IMARX_GROUPS*9-1:0] frame_len_out,
  // group controls
  output logic [imarx_pkg::IMARX_GROUPS-1:0] group_en_out,
  output logic [imarx_pkg::IMARX_GROUPS-1:0] usable_to_active_ok_out,
  output logic [imarx_pkg::IMARX_GROUPS-1:0] resync_en_out,
  output logic [imarx_pkg::IMARX_GROUPS-1:0] drain_out,
  output logic [imarx_pkg::IMARX_GROUPS*4-1:0] link_count_out
);
  import imarx_pkg::*;

  logic [IMARX_CW-1:0] count_reg [IMARX_GROUPS];
  logic [IMARX_CW-1:0] hold_reg [IMARX_GROUPS];
  logic [IMARX_GROUPS-1:0] snap_reg;
  logic [IMARX_DW-1:0] config_reg [IMARX_GROUPS];
  logic [IMARX_DW-1:0] control_reg [IMARX_GROUPS];

  function automatic logic [10:0] group_addr(input logic [10:0] base, input logic [10:0] step, input int g);
    logic [10:0] bank;
    logic [10:0] slot;
    bank = 11'((g / IMARX_PER_BANK) * IMARX_BANK_STEP);
    slot = 11'((g % IMARX_PER_BANK) * step);
    return base + bank + slot;
  endfunction : group_addr

  function automatic logic [8:0] m_of(input logic [1:0] code);
    case (code)
      2'h0: m_of = IMARX_M32;
      2'h1: m_of = IMARX_M64;
      2'h2: m_of = IMARX_M128;
      default: m_of = IMARX_M256;
    endcase
  endfunction : m_of

  // counters, holding copies and snapshot mode
  always_ff @(posedge clk_in) begin
    for (int g = 0; g < IMARX_GROUPS; g++) begin
      if (srst_in) begin
        count_reg[g] <= IMARX_CNT_RST;
        hold_reg[g] <= IMARX_CNT_RST;
        snap_reg[g] <= 1'b0;
      end else begin
        if (wr_in && addr_in == group_addr(IMARX_CNT_LOW_BASE, IMARX_CNT_STEP, g) && wdata_in == IMARX_SNAP_CMD) begin
          hold_reg[g] <= count_reg[g];
          count_reg[g] <= cell_in[g] ? IMARX_CNT_ONE : IMARX_CNT_RST;
          snap_reg[g] <= 1'b1;
        end else begin
          if (cell_in[g])
            count_reg[g] <= count_reg[g] + IMARX_CNT_ONE;
          if (wr_in && addr_in == group_addr(IMARX_CNT_LOW_BASE, IMARX_CNT_STEP, g) && wdata_in == IMARX_LIVE_CMD)
            snap_reg[g] <= 1'b0;
          else if (rd_in && snap_reg[g] && addr_in == group_addr(IMARX_CNT_HIGH_BASE, IMARX_CNT_STEP, g))
            hold_reg[g] <= IMARX_CNT_RST; // high byte read in snapshot mode clears reported value, whether or not the low byte was read
        end
      end
    end
  end

  // configuration and control, reserved bits kept zero
  always_ff @(posedge clk_in) begin
    for (int g = 0; g < IMARX_GROUPS; g++) begin
      if (srst_in) begin
        config_reg[g] <= IMARX_CONFIG_RST;
        control_reg[g] <= IMARX_CONTROL_RST;
      end else if (wr_in) begin
        if (addr_in == group_addr(IMARX_CONFIG_BASE, IMARX_CFG_STEP, g))
          config_reg[g] <= wdata_in & IMARX_CONFIG_MASK;
        if (addr_in == group_addr(IMARX_CONTROL_BASE, IMARX_CFG_STEP, g))
          control_reg[g] <= wdata_in & IMARX_CONTROL_MASK;
      end
    end
  end

  // read data, registered; live count or snapshot per group
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_out <= '0;
    end else begin
      rdata_out <= '0;
      if (rd_in) begin
        for (int g = 0; g < IMARX_GROUPS; g++) begin
          if (addr_in == group_addr(IMARX_CNT_LOW_BASE, IMARX_CNT_STEP, g))
            rdata_out <= snap_reg[g] ? hold_reg[g][7:0] : count_reg[g][7:0];
          if (addr_in == group_addr(IMARX_CNT_HIGH_BASE, IMARX_CNT_STEP, g))
            rdata_out <= snap_reg[g] ? hold_reg[g][15:8] : count_reg[g][15:8];
          if (addr_in == group_addr(IMARX_CONFIG_BASE, IMARX_CFG_STEP, g))
            rdata_out <= config_reg[g];
          if (addr_in == group_addr(IMARX_CONTROL_BASE, IMARX_CFG_STEP, g))
            rdata_out <= control_reg[g];
        end
      end
    end
  end

  // decoded controls towards framing, link state machine and delay buffer
  always_ff @(posedge clk_in) begin
    for (int g = 0; g < IMARX_GROUPS; g++) begin
      if (srst_in) begin
        check_id_out[g] <= 1'b0;
        acquire_len_out[g] <= 1'b0;
        symmetry_out[g*2 +: 2] <= IMARX_SYM_CFG_OP;
        frame_len_out[g*9 +: 9] <= IMARX_M32;
        group_en_out[g] <= 1'b0;
        usable_to_active_ok_out[g] <= 1'b0;
        resync_en_out[g] <= 1'b0;
        drain_out[g] <= 1'b0;
        link_count_out[g*4 +: 4] <= IMARX_LINKS_ONE;
      end else begin
        check_id_out[g] <= config_reg[g][IMARX_CFG_CHKID];
        acquire_len_out[g] <= config_reg[g][IMARX_CFG_ACQ];
        symmetry_out[g*2 +: 2] <= config_reg[g][IMARX_CFG_SYM_HI:IMARX_CFG_SYM_LO];
        frame_len_out[g*9 +: 9] <= m_of(config_reg[g][IMARX_CFG_M_HI:IMARX_CFG_M_LO]);
        group_en_out[g] <= control_reg[g][IMARX_CTL_EN];
        usable_to_active_ok_out[g] <= control_reg[g][IMARX_CTL_TMO];
        resync_en_out[g] <= control_reg[g][IMARX_CTL_RESYNC];
        drain_out[g] <= control_reg[g][IMARX_CTL_DRAIN];
        link_count_out[g*4 +: 4] <= {1'b0, control_reg[g][IMARX_CTL_SIZE_HI:IMARX_CTL_SIZE_LO]} + IMARX_LINKS_ONE;
      end
    end
  end

  // checks, group 0 stands for all
  property p_snap_clears;
    @(posedge clk_in) disable iff (srst_in)
    (wr_in && addr_in == IMARX_CNT_LOW_BASE && wdata_in == IMARX_SNAP_CMD && !cell_in[0])
      |=> count_reg[0] == IMARX_CNT_RST && hold_reg[0] == $past(count_reg[0]) && snap_reg[0];
  endproperty
  a_snap_clears: assert property (p_snap_clears) else $error("snapshot did not capture and clear");

  property p_count_inc;
    @(posedge clk_in) disable iff (srst_in)
    (cell_in[0] && !wr_in) |=> count_reg[0] == 16'($past(count_reg[0]) + IMARX_CNT_ONE);
  endproperty
  a_count_inc: assert property (p_count_inc) else $error("cell not counted");

  property p_wrap;
    @(posedge clk_in) disable iff (srst_in)
    (cell_in[0] && !wr_in && count_reg[0] == '1) |=> count_reg[0] == IMARX_CNT_RST;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");

  property p_live;
    @(posedge clk_in) disable iff (srst_in)
    (wr_in && addr_in == IMARX_CNT_LOW_BASE && wdata_in == IMARX_LIVE_CMD) |=> !snap_reg[0];
  endproperty
  a_live: assert property (p_live) else $error("live view not restored");

  property p_high_read;
    @(posedge clk_in) disable iff (srst_in)
    (rd_in && addr_in == IMARX_CNT_HIGH_BASE && snap_reg[0] && !wr_in)
      |=> rdata_out == $past(hold_reg[0][15:8]) && hold_reg[0] == IMARX_CNT_RST;
  endproperty
  a_high_read: assert property (p_high_read) else $error("high byte read wrong or not cleared");

  property p_low_read;
    @(posedge clk_in) disable iff (srst_in)
    (rd_in && addr_in == IMARX_CNT_LOW_BASE && !snap_reg[0]) |=> rdata_out == $past(count_reg[0][7:0]);
  endproperty
  a_low_read: assert property (p_low_read) else $error("low byte not live count");

  property p_ctl_follow;
    @(posedge clk_in) disable iff (srst_in)
    (wr_in && addr_in == IMARX_CONTROL_BASE) |=> ##1 group_en_out[0] == $past(wdata_in[IMARX_CTL_EN], 2)
      && usable_to_active_ok_out[0] == $past(wdata_in[IMARX_CTL_TMO], 2)
      && resync_en_out[0] == $past(wdata_in[IMARX_CTL_RESYNC], 2) && drain_out[0] == $past(wdata_in[IMARX_CTL_DRAIN], 2);
  endproperty
  a_ctl_follow: assert property (p_ctl_follow) else $error("control bits not applied");

  property p_size;
    @(posedge clk_in) disable iff (srst_in)
    (wr_in && addr_in == IMARX_CONTROL_BASE)
      |=> ##1 link_count_out[3:0] == 4'($past(wdata_in[IMARX_CTL_SIZE_HI:IMARX_CTL_SIZE_LO], 2)) + IMARX_LINKS_ONE;
  endproperty
  a_size: assert property (p_size) else $error("link count wrong");

  property p_cfg_follow;
    @(posedge clk_in) disable iff (srst_in)
    (wr_in && addr_in == IMARX_CONFIG_BASE) |=> ##1 check_id_out[0] == $past(wdata_in[IMARX_CFG_CHKID], 2)
      && acquire_len_out[0] == $past(wdata_in[IMARX_CFG_ACQ], 2)
      && symmetry_out[1:0] == $past(wdata_in[IMARX_CFG_SYM_HI:IMARX_CFG_SYM_LO], 2)
      && frame_len_out[8:0] == (IMARX_M32 << $past(wdata_in[IMARX_CFG_M_HI:IMARX_CFG_M_LO], 2));
  endproperty
  a_cfg_follow: assert property (p_cfg_follow) else $error("config not applied");

  c_snap: cover property (@(posedge clk_in) disable iff (srst_in)
    wr_in && addr_in == IMARX_CNT_LOW_BASE && wdata_in == IMARX_SNAP_CMD);
  c_read_pair: cover property (@(posedge clk_in) disable iff (srst_in)
    snap_reg[0] && rd_in && addr_in == IMARX_CNT_LOW_BASE ##2 rd_in && addr_in == IMARX_CNT_HIGH_BASE);
  c_enable: cover property (@(posedge clk_in) disable iff (srst_in) group_en_out[0]);
endmodule : imarx_group_regs

// *** verilog/imarx_pkg.sv ***
package imarx_pkg;
  localparam int unsigned IMARX_GROUPS = 16;
  localparam int unsigned IMARX_AW = 11;
  localparam int unsigned IMARX_DW = 8;
  localparam int unsigned IMARX_CW = 16;
  // per-group address: base of block + group bank + slot within bank
  localparam logic [10:0] IMARX_CNT_LOW_BASE = 11'h450;
  localparam logic [10:0] IMARX_CNT_HIGH_BASE = 11'h451;
  localparam logic [10:0] IMARX_CONFIG_BASE = 11'h4D0;
  localparam logic [10:0] IMARX_CONTROL_BASE = 11'h4D1;
  localparam logic [10:0] IMARX_BANK_STEP = 11'h100;
  localparam logic [10:0] IMARX_CNT_STEP = 11'h002;
  localparam logic [10:0] IMARX_CFG_STEP = 11'h004;
  localparam int unsigned IMARX_PER_BANK = 4;
  localparam logic [7:0] IMARX_SNAP_CMD = 8'h01;
  localparam logic [7:0] IMARX_LIVE_CMD = 8'h00;
  localparam logic [7:0] IMARX_CONFIG_RST = 8'h00;
  localparam logic [7:0] IMARX_CONTROL_RST = 8'h00;
  localparam logic [7:0] IMARX_CONFIG_MASK = 8'hCF;
  localparam logic [7:0] IMARX_CONTROL_MASK = 8'hF7;
  localparam logic [15:0] IMARX_CNT_RST = 16'h0000;
  localparam logic [15:0] IMARX_CNT_ONE = 16'h0001;
  // config fields
  localparam int unsigned IMARX_CFG_CHKID = 7;
  localparam int unsigned IMARX_CFG_ACQ = 6;
  localparam int unsigned IMARX_CFG_SYM_HI = 3;
  localparam int unsigned IMARX_CFG_SYM_LO = 2;
  localparam int unsigned IMARX_CFG_M_HI = 1;
  localparam int unsigned IMARX_CFG_M_LO = 0;
  // control fields
  localparam int unsigned IMARX_CTL_EN = 7;
  localparam int unsigned IMARX_CTL_TMO = 6;
  localparam int unsigned IMARX_CTL_RESYNC = 5;
  localparam int unsigned IMARX_CTL_DRAIN = 4;
  localparam int unsigned IMARX_CTL_SIZE_HI = 2;
  localparam int unsigned IMARX_CTL_SIZE_LO = 0;
  localparam logic [3:0] IMARX_LINKS_ONE = 4'h1;
  // frame length M per code
  localparam logic [8:0] IMARX_M32 = 9'h020;
  localparam logic [8:0] IMARX_M64 = 9'h040;
  localparam logic [8:0] IMARX_M128 = 9'h080;
  localparam logic [8:0] IMARX_M256 = 9'h100;
  typedef enum logic [1:0] {
    IMARX_SYM_CFG_OP,
    IMARX_SYM_CFG_ASYM_OP,
    IMARX_ASYM_CFG_OP,
    IMARX_ALT_SYM
  } imarx_sym_type;
endpackage : imarx_pkg
